// ---- hpu_defs.svh ----
// hpu_defs.svh: constants of the host port unit (lane codes, widths, timing)
// assumes nothing; included by the package and both ends
`ifndef HPU_DEFS_SVH
`define HPU_DEFS_SVH

// ----------------------------------------------------------------------
// lane enable codes {lane3,lane2,lane1,lane0}, active low
// ----------------------------------------------------------------------
`define HPU_BE_WORD 4'h0
`define HPU_BE_LOW_HALF 4'hC
`define HPU_BE_HIGH_HALF 4'h3
`define HPU_BE_BYTE0 4'hE
`define HPU_BE_BYTE1 4'hD
`define HPU_BE_BYTE2 4'hB
`define HPU_BE_BYTE3 4'h7
`define HPU_BE_NONE 4'hF

// ----------------------------------------------------------------------
// geometry and reset values
// ----------------------------------------------------------------------
`define HPU_ADDR_W 15
`define HPU_DATA_W 32
`define HPU_BASE_W 12
`define HPU_BASE_RST 12'h030
`define HPU_REGS 8
`define HPU_IDX_W 3
`define HPU_CLK_NS 25

`endif

// ---- hpu_pkg.sv ----
// hpu_pkg.sv: types shared by both ends of the host port unit
// assumes hpu_defs.svh in the include path
`include "hpu_defs.svh"
package hpu_pkg;
  // access width decoded from lane enables
  typedef enum logic [2:0] {
    HPU_ACC_NONE = 3'b000,
    HPU_ACC_BYTE = 3'b001,
    HPU_ACC_HALF = 3'b010,
    HPU_ACC_WORD = 3'b011
  } hpu_acc_t;

  // host-side sequencer states
  typedef enum logic [2:0] {
    HPU_H_IDLE = 3'b000,
    HPU_H_ADDR = 3'b001,
    HPU_H_STRB = 3'b010,
    HPU_H_HOLD = 3'b011,
    HPU_H_DONE = 3'b100
  } hpu_hst_t;

  // host command kinds
  typedef enum logic [1:0] {
    HPU_CMD_ARD = 2'b00,
    HPU_CMD_AWR = 2'b01,
    HPU_CMD_SRD = 2'b10,
    HPU_CMD_SWR = 2'b11
  } hpu_cmd_t;
endpackage

// ---- hpu_bus_if.sv ----
// hpu_bus_if.sv: pins between the host and the device port
// assumes one shared clock; data lanes resolved here from output enables
`timescale 1ns/1ps
`include "hpu_defs.svh"
interface hpu_bus_if;
  // ----------------------------------------------------------------------
  // common
  // ----------------------------------------------------------------------
  logic [`HPU_ADDR_W-1:0] addr;
  logic bus_target_qualifier;
  logic lane0_select_n;
  logic lane1_select_n;
  logic lane2_select_n;
  logic lane3_select_n;
  logic data_port_select_n;
  logic addr_strobe_n;
  logic local_target_hit_n;
  logic [`HPU_DATA_W-1:0] host_data_o;
  logic [3:0] host_data_oe_n;
  logic [`HPU_DATA_W-1:0] dev_data_o;
  logic [3:0] dev_data_oe_n;
  logic [`HPU_DATA_W-1:0] host_data_lanes;
  // ----------------------------------------------------------------------
  // synchronous only
  // ----------------------------------------------------------------------
  logic sync_cycle_style_sel;
  logic sync_cycle_n;
  logic sync_write;
  // ----------------------------------------------------------------------
  // asynchronous only
  // ----------------------------------------------------------------------
  logic async_read_strobe_n;
  logic async_write_strobe_n;

  // wired lanes: device wins whenever it drives a lane, host only where the device is not driving
  genvar g;
  for (g = 0; g < 4; g++) begin : g_lane
    assign host_data_lanes[8*g+:8] = !dev_data_oe_n[g] ? dev_data_o[8*g+:8] :
                                     !host_data_oe_n[g] ? host_data_o[8*g+:8] : 8'h00;
  end

  modport host (
    output addr, bus_target_qualifier, lane0_select_n, lane1_select_n,
    output lane2_select_n, lane3_select_n, data_port_select_n, addr_strobe_n,
    output host_data_o, host_data_oe_n, sync_cycle_style_sel, sync_cycle_n,
    output sync_write, async_read_strobe_n, async_write_strobe_n,
    input local_target_hit_n, host_data_lanes
  );
  modport dev (
    input addr, bus_target_qualifier, lane0_select_n, lane1_select_n,
    input lane2_select_n, lane3_select_n, data_port_select_n, addr_strobe_n,
    input host_data_lanes, sync_cycle_style_sel, sync_cycle_n, sync_write,
    input async_read_strobe_n, async_write_strobe_n,
    output local_target_hit_n, dev_data_o, dev_data_oe_n
  );
endinterface

// ---- hpu_dev_port.sv ----
// hpu_dev_port.sv: device end of the host port unit, lane decode and registers
// assumes inputs synchronous to clock; host keeps sync and async apart
`timescale 1ns/1ps
`include "hpu_defs.svh"
module hpu_dev_port
  import hpu_pkg::*;
#(
  parameter int BUS_W = `HPU_DATA_W,
  parameter logic [`HPU_BASE_W-1:0] BASE = `HPU_BASE_RST
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // pins
  hpu_bus_if.dev bus,
  // user side: latched decode and status
  output logic [`HPU_ADDR_W-1:0] user_addr,
  output hpu_acc_t user_acc,
  output logic [3:0] user_lanes,
  output logic user_wr_pulse,
  output logic [`HPU_DATA_W-1:0] user_wr_data,
  output logic user_reject_pulse
);

  if (BUS_W != 8 && BUS_W != 16 && BUS_W != 32) begin : g_bad_width
    $error("hpu_dev_port: BUS_W must be 8, 16 or 32");
  end

  // ----------------------------------------------------------------------
  // lane decode
  // ----------------------------------------------------------------------
  // returns lane mask, zero when the code is illegal for the bus width
  function automatic logic [3:0] lane_mask(input logic [3:0] be_n, input logic dsel_n);
    logic [3:0] m;
    m = 4'h0;
    if (!dsel_n) begin
      m = 4'hF;
    end else begin
      case (be_n)
        `HPU_BE_WORD: m = 4'hF;
        `HPU_BE_LOW_HALF: m = 4'h3;
        `HPU_BE_HIGH_HALF: m = 4'hC;
        `HPU_BE_BYTE0: m = 4'h1;
        `HPU_BE_BYTE1: m = 4'h2;
        `HPU_BE_BYTE2: m = 4'h4;
        `HPU_BE_BYTE3: m = 4'h8;
        default: m = 4'h0;
      endcase
    end
    // widths beyond the physical bus are refused
    if (BUS_W == 16 && m[3:2] != 2'b00) m = 4'h0;
    if (BUS_W == 8 && m != 4'h1 && m != 4'h2) m = 4'h0;
    return m;
  endfunction

  function automatic hpu_acc_t acc_of(input logic [3:0] m);
    case (m)
      4'hF: return HPU_ACC_WORD;
      4'h3, 4'hC: return HPU_ACC_HALF;
      4'h1, 4'h2, 4'h4, 4'h8: return HPU_ACC_BYTE;
      default: return HPU_ACC_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // address latch on strobe rising edge
  // ----------------------------------------------------------------------
  logic strobe_d_r;
  logic [`HPU_ADDR_W-1:0] addr_r;
  logic qual_r;
  logic [3:0] be_n_r;
  logic dsel_n_r;
  logic [3:0] mask;
  logic hit;
  logic rd_d_r;
  logic wr_d_r;
  logic scyc_d_r;
  logic xfer_rd;
  logic xfer_wr;
  logic [`HPU_DATA_W-1:0] rd_word;
  logic rise;
  logic [`HPU_ADDR_W-1:0] addr_eff;
  logic qual_eff;
  logic [3:0] be_n_eff;
  logic dsel_n_eff;
  logic [`HPU_IDX_W-1:0] idx;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      strobe_d_r <= 1'b1;
    end else begin
      strobe_d_r <= bus.addr_strobe_n;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      addr_r <= '0;
      qual_r <= 1'b1;
      be_n_r <= `HPU_BE_NONE;
      dsel_n_r <= 1'b1;
    end else if (rise) begin
      addr_r <= bus.addr;
      qual_r <= bus.bus_target_qualifier;
      be_n_r <= {bus.lane3_select_n, bus.lane2_select_n,
                 bus.lane1_select_n, bus.lane0_select_n};
      dsel_n_r <= bus.data_port_select_n;
    end
  end

  // hit is combinational: a glitch on address shows on the pin
  assign hit = !bus.bus_target_qualifier
               && (bus.addr[`HPU_ADDR_W-1:3] == BASE);
  assign bus.local_target_hit_n = !hit;
  // data strobe falls in the cycle the latch loads, so decode looks through it
  assign rise = bus.addr_strobe_n && !strobe_d_r;
  assign addr_eff = rise ? bus.addr : addr_r;
  assign qual_eff = rise ? bus.bus_target_qualifier : qual_r;
  assign be_n_eff = rise ? {bus.lane3_select_n, bus.lane2_select_n,
                            bus.lane1_select_n, bus.lane0_select_n} : be_n_r;
  assign dsel_n_eff = rise ? bus.data_port_select_n : dsel_n_r;
  assign mask = lane_mask(be_n_eff, dsel_n_eff);
  assign idx = addr_eff[`HPU_IDX_W-1:0];

  // ----------------------------------------------------------------------
  // transfer detection: async strobes or sync cycle, never both
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd_d_r <= 1'b1;
      wr_d_r <= 1'b1;
      scyc_d_r <= 1'b1;
    end else begin
      rd_d_r <= bus.async_read_strobe_n;
      wr_d_r <= bus.async_write_strobe_n;
      scyc_d_r <= bus.sync_cycle_n;
    end
  end

  // qualifier high is a dma cycle: never ours, even with data select low
  logic sel;
  assign sel = !qual_eff && (addr_eff[`HPU_ADDR_W-1:3] == BASE || !dsel_n_eff);
  // async via its strobes; sync via cycle with style-dependent direction
  logic sync_wr_cyc;
  logic sync_rd_cyc;
  assign sync_wr_cyc = !bus.sync_cycle_n && scyc_d_r
                       && (bus.sync_cycle_style_sel || bus.sync_write);
  assign sync_rd_cyc = !bus.sync_cycle_n && scyc_d_r
                       && !bus.sync_cycle_style_sel && !bus.sync_write;
  assign xfer_wr = sel && ((!bus.async_write_strobe_n && wr_d_r) || sync_wr_cyc);
  assign xfer_rd = sel && (!bus.async_read_strobe_n || sync_rd_cyc);

  // ----------------------------------------------------------------------
  // register bank, fixed byte lanes
  // ----------------------------------------------------------------------
  // one array per lane, so each lane process owns its own storage
  genvar gl;
  for (gl = 0; gl < 4; gl++) begin : g_wr
    logic [7:0] lane_r [`HPU_REGS];
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        for (int i = 0; i < `HPU_REGS; i++) lane_r[i] <= 8'h00;
      end else if (xfer_wr && mask[gl]) begin
        lane_r[idx] <= bus.host_data_lanes[8*gl+:8];
      end
    end
    assign rd_word[8*gl+:8] = lane_r[idx];
  end

  // read drive: only enabled lanes, lanes 2/3 only on a 32-bit bus
  always_comb begin
    bus.dev_data_o = rd_word;
    bus.dev_data_oe_n = ~({4{xfer_rd}} & mask);
  end

  // ----------------------------------------------------------------------
  // user side
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      user_addr <= '0;
      user_acc <= HPU_ACC_NONE;
      user_lanes <= 4'h0;
      user_wr_pulse <= 1'b0;
      user_wr_data <= '0;
      user_reject_pulse <= 1'b0;
    end else begin
      user_addr <= addr_eff;
      user_acc <= acc_of(mask);
      user_lanes <= mask;
      user_wr_pulse <= xfer_wr && (mask != 4'h0);
      user_wr_data <= bus.host_data_lanes;
      user_reject_pulse <= (xfer_wr || (xfer_rd && rd_d_r)) && (mask == 4'h0);
    end
  end

endmodule

// ---- hpu_host_end.sv ----
// hpu_host_end.sv: host end, runs one async or sync transfer per command
// assumes one shared clock with the device end
`timescale 1ns/1ps
`include "hpu_defs.svh"
module hpu_host_end
  import hpu_pkg::*;
#(
  parameter int BUS_W = `HPU_DATA_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // pins
  hpu_bus_if.host bus,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire hpu_cmd_t cmd_kind,
  input wire logic [`HPU_ADDR_W-1:0] cmd_addr,
  input wire logic [3:0] cmd_be_n,
  input wire logic cmd_qual,
  input wire logic cmd_dsel_n,
  input wire logic cmd_burst,
  input wire logic [`HPU_DATA_W-1:0] cmd_wdata,
  // answer
  output logic rsp_valid,
  output logic [`HPU_DATA_W-1:0] rsp_rdata
);

  if (BUS_W != 8 && BUS_W != 16 && BUS_W != 32) begin : g_bad_width
    $error("hpu_host_end: BUS_W must be 8, 16 or 32");
  end

  hpu_hst_t st_r;
  hpu_cmd_t kind_r;
  logic [3:0] lane_oe_n;

  // one transfer at a time, so sync and async never overlap
  assign cmd_ready = (st_r == HPU_H_IDLE);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r <= HPU_H_IDLE;
      kind_r <= HPU_CMD_ARD;
    end else begin
      case (st_r)
        HPU_H_IDLE: if (cmd_valid) begin
          st_r <= HPU_H_ADDR;
          kind_r <= cmd_kind;
        end
        HPU_H_ADDR: st_r <= HPU_H_STRB;
        HPU_H_STRB: st_r <= HPU_H_HOLD;
        HPU_H_HOLD: st_r <= HPU_H_DONE;
        HPU_H_DONE: st_r <= HPU_H_IDLE;
        default: st_r <= HPU_H_IDLE;
      endcase
    end
  end

  // address phase: strobe low in ADDR, rising edge latches at STRB
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bus.addr <= '0;
      bus.bus_target_qualifier <= 1'b1;
      {bus.lane3_select_n, bus.lane2_select_n, bus.lane1_select_n,
       bus.lane0_select_n} <= `HPU_BE_NONE;
      bus.data_port_select_n <= 1'b1;
      bus.sync_cycle_style_sel <= 1'b0;
      bus.host_data_o <= '0;
    end else if (st_r == HPU_H_IDLE && cmd_valid) begin
      bus.addr <= cmd_addr;
      bus.bus_target_qualifier <= cmd_qual;
      {bus.lane3_select_n, bus.lane2_select_n, bus.lane1_select_n,
       bus.lane0_select_n} <= cmd_be_n;
      bus.data_port_select_n <= cmd_dsel_n;
      bus.sync_cycle_style_sel <= cmd_burst;
      // 8-bit host copies its byte to lane 1 too 16-bit leaves upper off
      bus.host_data_o <= (BUS_W == 8) ? {16'h0000, cmd_wdata[7:0], cmd_wdata[7:0]}
                       : (BUS_W == 16) ? {16'h0000, cmd_wdata[15:0]} : cmd_wdata;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bus.addr_strobe_n <= 1'b1;
    end else begin
      bus.addr_strobe_n <= !(st_r == HPU_H_IDLE && cmd_valid);
    end
  end

  // data strobes one cycle wide in STRB; sync_cycle_n and sync_write idle during async
  logic is_wr;
  logic is_sync;
  assign is_wr = (kind_r == HPU_CMD_AWR) || (kind_r == HPU_CMD_SWR);
  assign is_sync = (kind_r == HPU_CMD_SRD) || (kind_r == HPU_CMD_SWR);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bus.async_read_strobe_n <= 1'b1;
      bus.async_write_strobe_n <= 1'b1;
      bus.sync_cycle_n <= 1'b1;
      bus.sync_write <= 1'b0;
    end else begin
      bus.async_read_strobe_n <= !(st_r == HPU_H_ADDR && !is_sync && !is_wr);
      bus.async_write_strobe_n <= !(st_r == HPU_H_ADDR && !is_sync && is_wr);
      bus.sync_cycle_n <= !(st_r == HPU_H_ADDR && is_sync);
      bus.sync_write <= (st_r == HPU_H_ADDR) && is_sync && is_wr;
    end
  end

  // drive lanes only during writes and only those wired for the width
  always_comb begin
    lane_oe_n = 4'hF;
    if (is_wr && (st_r == HPU_H_STRB || st_r == HPU_H_HOLD)) begin
      lane_oe_n = (BUS_W == 32) ? 4'h0 : 4'hC;
    end
    bus.host_data_oe_n = lane_oe_n;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= (st_r == HPU_H_HOLD);
      if (st_r == HPU_H_STRB && !is_wr) rsp_rdata <= bus.host_data_lanes;
    end
  end

endmodule

// ---- hpu_bus_asserts.sv ----
// hpu_bus_asserts.sv: pin checks between the host end and the device end
// assumes one clock; instantiated once beside one bus interface
`timescale 1ns/1ps
`include "hpu_defs.svh"
module hpu_bus_asserts #(
  parameter int BUS_W = `HPU_DATA_W,
  parameter logic [`HPU_BASE_W-1:0] BASE = `HPU_BASE_RST
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // common
  input wire logic [`HPU_ADDR_W-1:0] addr,
  input wire logic bus_target_qualifier,
  input wire logic lane0_select_n,
  input wire logic lane1_select_n,
  input wire logic lane2_select_n,
  input wire logic lane3_select_n,
  input wire logic data_port_select_n,
  input wire logic addr_strobe_n,
  input wire logic local_target_hit_n,
  input wire logic [3:0] dev_data_oe_n,
  // transfer controls
  input wire logic sync_cycle_style_sel,
  input wire logic sync_cycle_n,
  input wire logic async_read_strobe_n,
  input wire logic async_write_strobe_n
);
  logic q_r;
  logic ds_r;
  logic [3:0] be_r;
  logic [`HPU_BASE_W-1:0] top_r;
  logic [3:0] code;
  logic drive_ok;

  function automatic logic lane_ok(input logic [3:0] c);
    case (c)
      4'hE, 4'hD: lane_ok = 1'b1;
      4'hC: lane_ok = BUS_W >= 16;
      4'h0, 4'h3, 4'hB, 4'h7: lane_ok = BUS_W == 32;
      default: lane_ok = 1'b0;
    endcase
  endfunction

  // shadow of the latched decode, taken while the strobe is low
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      q_r <= 1'b1;
      ds_r <= 1'b1;
      be_r <= 4'hF;
      top_r <= '0;
    end else if (!addr_strobe_n) begin
      q_r <= bus_target_qualifier;
      ds_r <= data_port_select_n;
      be_r <= {lane3_select_n, lane2_select_n, lane1_select_n, lane0_select_n};
      top_r <= addr[`HPU_ADDR_W-1:3];
    end
  end

  always_comb begin
    code = ds_r ? be_r : 4'h0;
    drive_ok = !q_r && (!ds_r || top_r == BASE) && lane_ok(code);
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  a_hit_decode: assert property (
    local_target_hit_n == !(!bus_target_qualifier && addr[`HPU_ADDR_W-1:3] == BASE))
    else $error("hit output differs from address decode");
  a_read_lanes: assert property (
    (!async_read_strobe_n && drive_ok) |-> dev_data_oe_n == code)
    else $error("read drives the wrong lanes");
  a_unsel_quiet: assert property (
    !drive_ok |-> dev_data_oe_n == 4'hF)
    else $error("device drives lanes without a legal selected access");
  a_upper_idle: assert property (
    BUS_W < 32 |-> dev_data_oe_n[3:2] == 2'b11)
    else $error("upper lanes driven on a narrow bus");
  a_latch_first: assert property (
    ($fell(async_read_strobe_n) || $fell(async_write_strobe_n) || $fell(sync_cycle_n))
    |-> $past(addr_strobe_n) == 1'b0)
    else $error("strobe without a preceding address strobe");
  a_strobe_then_xfer: assert property (
    $fell(addr_strobe_n) |=> addr_strobe_n
      && (!async_read_strobe_n || !async_write_strobe_n || !sync_cycle_n))
    else $error("address strobe not followed by a transfer strobe");
  a_no_overlap: assert property (
    !((!async_read_strobe_n || !async_write_strobe_n) && !sync_cycle_n))
    else $error("sync and async transfers overlap");
  a_async_quiet: assert property (
    (!async_read_strobe_n || !async_write_strobe_n)
    |-> sync_cycle_n && $stable(sync_cycle_style_sel))
    else $error("sync controls move during an async transfer");
  a_strobe_short: assert property (
    ($fell(async_write_strobe_n) || $fell(async_read_strobe_n))
    |=> async_write_strobe_n && async_read_strobe_n)
    else $error("async strobe held longer than one cycle");
endmodule

// ---- test_host_bus_lane_decode.sv ----
// test_host_bus_lane_decode.sv: host end against device end at 32, 16 and 8 bits
// assumes the design files and hpu_bus_asserts.sv are compiled first
`timescale 1ns/1ps
`include "hpu_defs.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module test_host_bus_lane_decode;
  import hpu_pkg::*;
  logic clock;
  logic resetn;
  logic cmd_valid;
  hpu_cmd_t cmd_kind;
  logic [14:0] cmd_addr;
  logic [3:0] cmd_be_n;
  logic cmd_qual;
  logic cmd_dsel_n;
  logic cmd_burst;
  logic [31:0] cmd_wdata;
  logic cmd_ready [3];
  logic rsp_valid [3];
  logic [31:0] rsp_rdata [3];
  logic [14:0] user_addr [3];
  hpu_acc_t user_acc [3];
  logic user_wr_pulse [3];
  logic [31:0] user_wr_data [3];
  logic user_reject_pulse [3];
  logic [3:0] user_lanes [3];
  int fail_count = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'hFDBF0C55;
  logic [14:0] ad;
  logic [31:0] r;
  logic [3:0] codes [7] = '{4'h0, 4'hC, 4'h3, 4'hE, 4'hD, 4'hB, 4'h7};

  // ----------------------------------------------------------------------
  // one pair per bus width, all fed the same commands
  // ----------------------------------------------------------------------
  for (genvar k = 0; k < 3; k++) begin : g_pair
    hpu_bus_if bus_i ();
    hpu_host_end #(.BUS_W(32 >> k)) hpu_host_end_i (.clock(clock), .resetn(resetn),
      .bus(bus_i), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready[k]), .cmd_kind(cmd_kind),
      .cmd_addr(cmd_addr), .cmd_be_n(cmd_be_n), .cmd_qual(cmd_qual),
      .cmd_dsel_n(cmd_dsel_n), .cmd_burst(cmd_burst), .cmd_wdata(cmd_wdata),
      .rsp_valid(rsp_valid[k]), .rsp_rdata(rsp_rdata[k]));
    hpu_dev_port #(.BUS_W(32 >> k)) hpu_dev_port_i (.clock(clock), .resetn(resetn),
      .bus(bus_i), .user_addr(user_addr[k]), .user_acc(user_acc[k]),
      .user_lanes(user_lanes[k]),
      .user_wr_pulse(user_wr_pulse[k]), .user_wr_data(user_wr_data[k]),
      .user_reject_pulse(user_reject_pulse[k]));
    // watched on the 16-bit pair: refused codes and idle upper lanes occur there
    if (k == 1) begin : g_chk
      hpu_bus_asserts #(.BUS_W(16)) hpu_bus_asserts_i (.clock(clock), .resetn(resetn),
        .addr(bus_i.addr), .bus_target_qualifier(bus_i.bus_target_qualifier),
        .lane0_select_n(bus_i.lane0_select_n), .lane1_select_n(bus_i.lane1_select_n),
        .lane2_select_n(bus_i.lane2_select_n), .lane3_select_n(bus_i.lane3_select_n),
        .data_port_select_n(bus_i.data_port_select_n), .addr_strobe_n(bus_i.addr_strobe_n),
        .local_target_hit_n(bus_i.local_target_hit_n), .dev_data_oe_n(bus_i.dev_data_oe_n),
        .sync_cycle_style_sel(bus_i.sync_cycle_style_sel), .sync_cycle_n(bus_i.sync_cycle_n),
        .async_read_strobe_n(bus_i.async_read_strobe_n),
        .async_write_strobe_n(bus_i.async_write_strobe_n));
    end
  end

  always #(`HPU_CLK_NS / 2.0) clock = ~clock;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic lane_ok(input logic [3:0] c, input int w);
    case (c)
      4'hE, 4'hD: return 1'b1;
      4'hC: return w >= 16;
      4'h0, 4'h3, 4'hB, 4'h7: return w == 32;
      default: return 1'b0;
    endcase
  endfunction

  function automatic hpu_acc_t acc_of(input logic [3:0] c);
    case (c)
      4'h0: return HPU_ACC_WORD;
      4'hC, 4'h3: return HPU_ACC_HALF;
      default: return HPU_ACC_BYTE;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
      input logic [3:0] c);
    for (int b = 0; b < 4; b++) if (!c[b]) o[8*b+:8] = n[8*b+:8];
    return o;
  endfunction

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // one command; counts what every width does with it
  task automatic xfer(input hpu_cmd_t kd, input logic [14:0] a, input logic [3:0] be,
      input logic q, input logic dn, input logic bu, input logic [31:0] d);
    int wr [3] = '{0, 0, 0};
    int rj [3] = '{0, 0, 0};
    int rv = -1;
    hpu_acc_t acc [3] = '{HPU_ACC_NONE, HPU_ACC_NONE, HPU_ACC_NONE};
    logic [14:0] ua [3];
    logic [3:0] ul [3];
    logic [31:0] wd = '0;
    logic [3:0] c = dn ? be : 4'h0;
    logic sel = !q && (!dn || a[14:3] == `HPU_BASE_RST);
    logic is_wr = kd == HPU_CMD_AWR || kd == HPU_CMD_SWR;
    for (int i = 0; i < 8 && cmd_ready[0] !== 1'b1; i++) @(negedge clock);
    {cmd_kind, cmd_addr, cmd_be_n, cmd_qual, cmd_dsel_n, cmd_burst} = {kd, a, be, q, dn, bu};
    cmd_wdata = d;
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
    for (int n = 0; n < 6; n++) begin
      if (rsp_valid[0] === 1'b1 && rv < 0) rv = n;
      for (int k = 0; k < 3; k++) begin
        rj[k] += int'(user_reject_pulse[k] === 1'b1);
        if (user_wr_pulse[k] === 1'b1) begin
          wr[k]++;
          acc[k] = user_acc[k];
          ua[k] = user_addr[k];
          ul[k] = user_lanes[k];
        end
      end
      if (user_wr_pulse[0] === 1'b1) wd = user_wr_data[0];
      @(negedge clock);
    end
    // n counts falling edges after the taking edge; the answer stands before edge 4
    `CHK("answer_delay", 3, rv)
    for (int k = 0; k < 3; k++) begin
      `CHK("write_count", int'(is_wr && sel && lane_ok(c, 32 >> k)), wr[k])
      `CHK("reject_count", int'(sel && !lane_ok(c, 32 >> k)), rj[k])
      if (wr[k] == 1) begin
        `CHK("access_width", acc_of(c), acc[k])
        `CHK("latched_addr", a, ua[k])
        `CHK("lane_mask", ~c, ul[k])
      end
    end
    if (wr[0] == 1 && c == 4'h0) `CHK("word_data", d, wd)
  endtask

  initial begin
    #(`HPU_CLK_NS * 5000);
    fail_count++;
    end_of_test();
  end

  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    cmd_valid = 1'b0;
    {cmd_kind, cmd_addr, cmd_be_n, cmd_qual, cmd_dsel_n, cmd_burst} = '0;
    cmd_wdata = '0;
    repeat (6) @(negedge clock);
    resetn = 1'b1;
    // every lane code merged into a known word, read back async and sync
    for (int i = 0; i < 7; i++) begin
      ad = {`HPU_BASE_RST, i[2:0]};
      xfer(HPU_CMD_AWR, ad, 4'h0, 1'b0, 1'b1, 1'b0, 32'h1122_3344);
      xfer(HPU_CMD_SWR, ad, codes[i], 1'b0, 1'b1, i[1], 32'hA5C3_9E0F);
      xfer(i[0] ? HPU_CMD_SRD : HPU_CMD_ARD, ad, 4'h0, 1'b0, 1'b1, 1'b0, 32'h0);
      r = merge(32'h1122_3344, 32'hA5C3_9E0F, codes[i]);
      `CHK("read_back", r, rsp_rdata[0])
      // narrow read: only enabled lanes carry data, the rest read as zero
      xfer(HPU_CMD_ARD, ad, codes[i], 1'b0, 1'b1, 1'b0, 32'h0);
      `CHK("lane_read", merge(32'h0, r, codes[i]), rsp_rdata[0])
    end
    // random writes: qualifier, data select, style and illegal codes mixed in
    repeat (150) begin
      r = rnd();
      ad = r[0] ? {`HPU_BASE_RST, r[3:1]} : r[18:4];
      xfer(r[5] ? HPU_CMD_SWR : HPU_CMD_AWR, ad, r[6] ? codes[r[9:7] % 7] : r[13:10],
        r[20] & r[21], !(r[22] & r[23]), r[24], rnd());
    end
    end_of_test();
  end
endmodule
